/* File: plcdm_addr_decode.sv */
// operand address decoder: area, word, bit and access legality
`timescale 1ns/1ps
module plcdm_addr_decode (
  input wire logic [15:0] addr,
  plcdm_dec_if.src dec
);
  function automatic logic inRange(input logic [11:0] v, input logic [11:0] last);
    inRange = (v <= last);
  endfunction

  always_comb begin
    logic [11:0] idx;
    logic numbered;
    idx = addr[11:0];
    numbered = 1'b0;
    dec.area = plcdm_pkg::plcdm_area_e'(addr[plcdm_pkg::ADDR_AREA_LSB +: 3]);
    dec.bitMode = addr[plcdm_pkg::ADDR_BITMODE];
    // timer/counter and temporary bits are plain numbers, others append a bit number
    numbered = (dec.area == plcdm_pkg::AREA_TC) || (dec.area == plcdm_pkg::AREA_TEMP);
    dec.word = (dec.bitMode && !numbered) ? {4'h0, idx[11:4]} : idx;
    dec.bitNo = idx[3:0];
    dec.legal = 1'b0;
    dec.progWrOk = 1'b0;
    case (dec.area)
      plcdm_pkg::AREA_PLAIN: begin
        dec.legal = inRange(dec.word, plcdm_pkg::SP_LAST);
        dec.progWrOk = dec.legal;
      end
      plcdm_pkg::AREA_HOLD: begin
        dec.legal = inRange(dec.word, plcdm_pkg::HOLD_LAST);
        dec.progWrOk = dec.legal;
      end
      plcdm_pkg::AREA_AUX: begin
        dec.legal = inRange(dec.word, plcdm_pkg::AUX_LAST);
        dec.progWrOk = dec.legal && (dec.word >= plcdm_pkg::AUX_FREE_FIRST)
          && (dec.word <= plcdm_pkg::AUX_FREE_LAST);
      end
      plcdm_pkg::AREA_LINK: begin
        dec.legal = inRange(dec.word, plcdm_pkg::LINK_LAST);
        dec.progWrOk = dec.legal;
      end
      plcdm_pkg::AREA_DM: begin
        dec.legal = !dec.bitMode && inRange(dec.word, plcdm_pkg::DM_LAST);
        dec.progWrOk = dec.legal && (dec.word < plcdm_pkg::DM_RO_FIRST);
      end
      plcdm_pkg::AREA_TC: begin
        dec.legal = inRange(dec.word, plcdm_pkg::TC_LAST);
        dec.progWrOk = 1'b0;
      end
      plcdm_pkg::AREA_TEMP: begin
        dec.legal = dec.bitMode && inRange(dec.word, plcdm_pkg::TEMP_LAST);
        dec.progWrOk = dec.legal;
      end
      plcdm_pkg::AREA_CFG: begin
        dec.legal = !dec.bitMode && inRange(dec.word, plcdm_pkg::CFG_LAST);
        dec.progWrOk = dec.legal;
      end
      default: begin
        dec.legal = 1'b0;
        dec.progWrOk = 1'b0;
      end
    endcase
  end
endmodule

/* File: plcdm_data_area_map.sv */
// controller data-area map: operand decode, area storage and special-area words
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module plcdm_data_area_map (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [15:0] addr,
  input wire logic [15:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [15:0] rdData,
  output logic accessError,
  input wire logic unitWr,
  input wire logic [2:0] unitArea,
  input wire logic [11:0] unitIdx,
  input wire logic [15:0] unitData,
  input wire logic [7:0] unitRdIdx,
  output logic [15:0] unitRdData,
  input wire logic tcWr,
  input wire logic [8:0] tcIdx,
  input wire logic [15:0] tcPv,
  input wire logic tcDone,
  input wire logic runStart,
  input wire logic [15:0] nodeLoopStatus,
  input wire logic [1:0] netDone,
  input wire logic [7:0] netCode0,
  input wire logic [7:0] netCode1,
  input wire logic [3:0][15:0] linkStatus0,
  input wire logic [3:0][15:0] linkStatus1,
  input wire logic [3:0][15:0] peerStatus,
  input wire logic [15:0] remoteIoErrors,
  input wire logic [5:0] linkFlags,
  input wire logic [2:0] hostErrors,
  input wire logic [2:0] restartDone,
  input wire logic [7:0] alarmNumber,
  input wire logic lowBattery,
  input wire logic cycleTimeError,
  input wire logic ioVerifyError,
  output logic [2:0] restartReq,
  output logic outputsOff,
  output logic forcedHold,
  output logic ioHold
);
  logic [1:0] rstPipe;
  logic rstSync_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe[1];

  plcdm_dec_if dec ();
  plcdm_addr_decode u_dec (
    .addr(addr),
    .dec(dec)
  );

  // area storage
  logic [15:0] ioMem [0:235];
  logic [15:0] ioNext [0:235];
  logic [15:0] spWork [0:15];
  logic [15:0] spWorkNext [0:15];
  logic [15:0] hrMem [0:99];
  logic [15:0] hrNext [0:99];
  logic [15:0] arMem [0:27];
  logic [15:0] arNext [0:27];
  logic [15:0] lrMem [0:63];
  logic [15:0] lrNext [0:63];
  logic [15:0] dmMem [0:1999];
  logic [15:0] dmNext [0:1999];
  logic [15:0] tcPvMem [0:511];
  logic [15:0] tcPvNext [0:511];
  logic [511:0] tcFlag;
  logic [511:0] tcFlagNext;
  logic [7:0] trBit;
  logic [7:0] trNext;

  logic [15:0] useMask_reg;
  logic [15:0] useMask_next;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] rdData_reg;
  logic [15:0] rdData_next;
  logic accessError_reg;
  logic accessError_next;
  logic [15:0] unitRd_reg;
  logic [15:0] unitRd_next;

  logic [15:0] netCodeWord;
  logic [15:0] linkCtrlWord;
  logic [15:0] hwBits252;
  logic [15:0] alarmWord;
  logic prog252;

  assign hwBits252 = {7'h00, hostErrors[1], 1'b0, hostErrors[0], linkFlags};
  assign alarmWord = {4'h0, hostErrors[2], ioVerifyError, cycleTimeError, lowBattery,
    alarmNumber};

  // special-area word: dedicated value or work storage when its function is unused
  function automatic logic [15:0] specialWord(input logic [11:0] w);
    logic [3:0] k;
    k = w[3:0] - plcdm_pkg::SP_FIRST[3:0];
    specialWord = 16'h0000;
    if (w <= plcdm_pkg::SP_WORK_LAST && !useMask_reg[k]) begin
      specialWord = spWork[k];
    end else if (w == plcdm_pkg::REG_NODE_LOOP) begin
      specialWord = nodeLoopStatus;
    end else if (w == plcdm_pkg::REG_NET_CODE) begin
      specialWord = netCodeWord;
    end else if (w >= plcdm_pkg::REG_L0_LINK && w < plcdm_pkg::REG_L1_LINK) begin
      specialWord = linkStatus0[w[1:0] - plcdm_pkg::REG_L0_LINK[1:0]];
    end else if (w >= plcdm_pkg::REG_L1_LINK && w < plcdm_pkg::REG_UNUSED) begin
      specialWord = linkStatus1[w[1:0] - plcdm_pkg::REG_L1_LINK[1:0]];
    end else if (w >= plcdm_pkg::REG_PEER && w < plcdm_pkg::REG_REMOTE_ERR) begin
      specialWord = peerStatus[w[1:0] - plcdm_pkg::REG_PEER[1:0]];
    end else if (w == plcdm_pkg::REG_REMOTE_ERR) begin
      specialWord = remoteIoErrors;
    end else if (w == plcdm_pkg::REG_LINK_CTRL) begin
      specialWord = linkCtrlWord;
    end else if (w == plcdm_pkg::REG_ALARM) begin
      specialWord = alarmWord;
    end
  endfunction

  // word value of every area but the temporary bits, used by reads and bit read-modify-write
  function automatic logic [15:0] readWord(input plcdm_pkg::plcdm_area_e a,
    input logic [11:0] w);
    readWord = 16'h0000;
    case (a)
      plcdm_pkg::AREA_PLAIN: begin
        readWord = (w <= plcdm_pkg::IO_LAST) ? ioMem[w[7:0]] : specialWord(w);
      end
      plcdm_pkg::AREA_HOLD: readWord = hrMem[w[6:0]];
      plcdm_pkg::AREA_AUX: readWord = arMem[w[4:0]];
      plcdm_pkg::AREA_LINK: readWord = lrMem[w[5:0]];
      plcdm_pkg::AREA_DM: readWord = dmMem[w[10:0]];
      plcdm_pkg::AREA_TC: readWord = tcPvMem[w[8:0]];
      plcdm_pkg::AREA_CFG: readWord = w[0] ? ctrl_reg : useMask_reg;
      default: readWord = 16'h0000;
    endcase
  endfunction

  // which areas and words the mounted units may fill
  function automatic logic unitMayWrite(input logic [2:0] a, input logic [11:0] w);
    unitMayWrite = 1'b0;
    case (a)
      3'h0: unitMayWrite = (w <= plcdm_pkg::IO_LOCAL_LAST)
        || (w >= plcdm_pkg::IO_REMOTE_FIRST && w <= plcdm_pkg::IO_REMOTE_LAST);
      3'h2: unitMayWrite = (w <= plcdm_pkg::AUX_LAST);
      3'h3: unitMayWrite = (w <= plcdm_pkg::LINK_LAST) && ctrl_reg[plcdm_pkg::CTRL_LINK_USE];
      3'h4: unitMayWrite = (w >= plcdm_pkg::DM_RO_FIRST && w <= plcdm_pkg::DM_LAST)
        || (plcdm_pkg::HAS_ERR_LOG && w >= plcdm_pkg::DM_LOG_FIRST
        && w <= plcdm_pkg::DM_LOG_LAST);
      default: unitMayWrite = 1'b0;
    endcase
  endfunction

  logic [15:0] curWord;
  logic [15:0] wrWord;
  logic progWe;
  logic unitWe;

  always_comb begin
    logic spOk;
    spOk = 1'b0;
    curWord = readWord(dec.area, dec.word);
    wrWord = dec.bitMode ? ((curWord & ~(16'h0001 << dec.bitNo))
      | ({15'h0000, wrData[0]} << dec.bitNo)) : wrData;
    // special words take program writes only as work storage or the control bits
    spOk = (dec.word <= plcdm_pkg::IO_LAST)
      || (dec.word <= plcdm_pkg::SP_WORK_LAST
      && !useMask_reg[dec.word[3:0] - plcdm_pkg::SP_FIRST[3:0]])
      || (dec.word == plcdm_pkg::REG_LINK_CTRL);
    progWe = wrStrobe && dec.progWrOk
      && ((dec.area != plcdm_pkg::AREA_PLAIN) || spOk);
    prog252 = progWe && (dec.area == plcdm_pkg::AREA_PLAIN)
      && (dec.word == plcdm_pkg::REG_LINK_CTRL);
    unitWe = unitWr && unitMayWrite(unitArea, unitIdx);
  end

  plcdm_net_status u_net (
    .clock(clock),
    .rstSync_n(rstSync_n),
    .netDone(netDone),
    .netCode0(netCode0),
    .netCode1(netCode1),
    .progWr(prog252),
    .progData(wrWord),
    .hwBits(hwBits252),
    .restartDone(restartDone),
    .codeWord(netCodeWord),
    .ctrlWord(linkCtrlWord)
  );

  // storage next values: program write first, unit write on the same word wins
  always_comb begin
    ioNext = ioMem;
    spWorkNext = spWork;
    hrNext = hrMem;
    arNext = arMem;
    lrNext = lrMem;
    dmNext = dmMem;
    tcPvNext = tcPvMem;
    tcFlagNext = tcFlag;
    trNext = trBit;
    if (runStart && !linkCtrlWord[plcdm_pkg::LC_IO_HOLD]) begin
      for (int i = 0; i <= 235; i++) begin
        ioNext[i] = 16'h0000;
      end
    end
    if (progWe) begin
      case (dec.area)
        plcdm_pkg::AREA_PLAIN: begin
          if (dec.word <= plcdm_pkg::IO_LAST) begin
            ioNext[dec.word[7:0]] = wrWord;
          end else if (dec.word <= plcdm_pkg::SP_WORK_LAST) begin
            spWorkNext[dec.word[3:0] - plcdm_pkg::SP_FIRST[3:0]] = wrWord;
          end
        end
        plcdm_pkg::AREA_HOLD: hrNext[dec.word[6:0]] = wrWord;
        plcdm_pkg::AREA_AUX: arNext[dec.word[4:0]] = wrWord;
        plcdm_pkg::AREA_LINK: lrNext[dec.word[5:0]] = wrWord;
        plcdm_pkg::AREA_DM: dmNext[dec.word[10:0]] = wrData;
        plcdm_pkg::AREA_TEMP: trNext[dec.word[2:0]] = wrData[0];
        default: ;
      endcase
    end
    if (unitWe) begin
      case (unitArea)
        3'h0: ioNext[unitIdx[7:0]] = unitData;
        3'h2: arNext[unitIdx[4:0]] = unitData;
        3'h3: lrNext[unitIdx[5:0]] = unitData;
        3'h4: dmNext[unitIdx[10:0]] = unitData;
        default: ;
      endcase
    end
    if (tcWr) begin
      tcPvNext[tcIdx] = tcPv;
      tcFlagNext[tcIdx] = tcDone;
    end
  end

  // area storage carries no reset: holding area and retained states survive it
  always_ff @(posedge clock) begin
    ioMem <= ioNext;
    spWork <= spWorkNext;
    hrMem <= hrNext;
    arMem <= arNext;
    lrMem <= lrNext;
    dmMem <= dmNext;
    tcPvMem <= tcPvNext;
    tcFlag <= tcFlagNext;
    trBit <= trNext;
  end

  // configuration, read answer and unit read port
  always_comb begin
    logic bitVal;
    bitVal = 1'b0;
    useMask_next = useMask_reg;
    ctrl_next = ctrl_reg;
    if (progWe && dec.area == plcdm_pkg::AREA_CFG) begin
      if (dec.word == plcdm_pkg::CFG_CTRL) begin
        ctrl_next = wrData;
      end else begin
        useMask_next = wrData;
      end
    end
    case (dec.area)
      plcdm_pkg::AREA_TC: bitVal = tcFlag[dec.word[8:0]];
      plcdm_pkg::AREA_TEMP: bitVal = trBit[dec.word[2:0]];
      default: bitVal = curWord[dec.bitNo];
    endcase
    rdData_next = 16'h0000;
    if (rdStrobe && dec.legal) begin
      rdData_next = dec.bitMode ? {15'h0000, bitVal} : curWord;
    end
    accessError_next = (rdStrobe && !dec.legal) || (wrStrobe && !progWe);
    unitRd_next = 16'h0000;
    if (unitRdIdx <= plcdm_pkg::IO_LAST[7:0] && !linkCtrlWord[plcdm_pkg::LC_OUT_OFF]) begin
      unitRd_next = ioMem[unitRdIdx];
    end
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      useMask_reg <= plcdm_pkg::CFG_USE_MASK_RESET;
      ctrl_reg <= plcdm_pkg::CFG_CTRL_RESET;
      rdData_reg <= 16'h0000;
      accessError_reg <= 1'b0;
      unitRd_reg <= 16'h0000;
    end else begin
      useMask_reg <= useMask_next;
      ctrl_reg <= ctrl_next;
      rdData_reg <= rdData_next;
      accessError_reg <= accessError_next;
      unitRd_reg <= unitRd_next;
    end
  end

  assign rdData = rdData_reg;
  assign accessError = accessError_reg;
  assign unitRdData = unitRd_reg;
  assign restartReq = {linkCtrlWord[plcdm_pkg::LC_HOST0_RST],
    linkCtrlWord[plcdm_pkg::LC_CPUHL_RST], linkCtrlWord[plcdm_pkg::LC_HOST1_RST]};
  assign outputsOff = linkCtrlWord[plcdm_pkg::LC_OUT_OFF];
  assign forcedHold = linkCtrlWord[plcdm_pkg::LC_FORCE_HOLD];
  assign ioHold = linkCtrlWord[plcdm_pkg::LC_IO_HOLD];
endmodule

/* File: plcdm_dec_if.sv */
// decoded operand address passed from the decoder to the map
`timescale 1ns/1ps
interface plcdm_dec_if;
  plcdm_pkg::plcdm_area_e area;
  logic [11:0] word;
  logic [3:0] bitNo;
  logic bitMode;
  logic legal;
  logic progWrOk;
  modport src (output area, output word, output bitNo, output bitMode, output legal,
    output progWrOk);
  modport snk (input area, input word, input bitNo, input bitMode, input legal,
    input progWrOk);
endinterface

/* File: plcdm_far_model.sv */
// far-side model: network, link, remote unit and alarm status levels
`timescale 1ns/1ps
module plcdm_far_model (
  output logic [15:0] nodeLoopStatus,
  output logic [3:0][15:0] linkStatus0,
  output logic [3:0][15:0] linkStatus1,
  output logic [3:0][15:0] peerStatus,
  output logic [15:0] remoteIoErrors,
  output logic [5:0] linkFlags,
  output logic [2:0] hostErrors,
  output logic [7:0] alarmNumber,
  output logic lowBattery,
  output logic cycleTimeError,
  output logic ioVerifyError
);
  assign nodeLoopStatus = 16'hA55A;
  assign linkStatus0 = {16'h4403, 16'h4402, 16'h4401, 16'h4400};
  assign linkStatus1 = {16'h8803, 16'h8802, 16'h8801, 16'h8800};
  assign peerStatus = {16'hC303, 16'hC302, 16'hC301, 16'hC300};
  assign remoteIoErrors = 16'hF00F;
  assign linkFlags = 6'h2D;
  assign hostErrors = 3'h5;
  assign alarmNumber = 8'hC3;
  assign lowBattery = 1'h1;
  assign cycleTimeError = 1'h0;
  assign ioVerifyError = 1'h1;
endmodule

/* File: plcdm_map_assertions.sv */
// port-level assertions for the data-area map
`timescale 1ns/1ps
module plcdm_map_assertions (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [15:0] addr,
  input wire logic [15:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [15:0] rdData,
  input wire logic accessError,
  input wire logic [7:0] unitRdIdx,
  input wire logic [15:0] unitRdData,
  input wire logic [2:0] restartDone,
  input wire logic [2:0] restartReq,
  input wire logic outputsOff,
  input wire logic ioHold
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_read_pulse: assert property (!rdStrobe |=> rdData == 16'h0000)
    else $error("read data outside its cycle");
  a_err_cause: assert property (accessError |-> $past(wrStrobe) || $past(rdStrobe))
    else $error("access error without a request");
  a_dm_readonly: assert property (wrStrobe && addr[15:12] == 4'h4
    && addr[11:0] >= 12'h3E8 |=> accessError) else $error("upper data memory write taken");
  a_dm_no_bits: assert property (rdStrobe && addr[15:12] == 4'hC
    |=> accessError && rdData == 16'h0000) else $error("data memory bit read taken");
  a_tc_no_write: assert property (wrStrobe && addr[14:12] == 3'h5 |=> accessError)
    else $error("timer write taken");
  a_tr_no_word: assert property ((wrStrobe || rdStrobe) && addr[15:12] == 4'h6
    |=> accessError) else $error("temporary word access taken");
  a_alarm_ro: assert property (wrStrobe && addr == 16'h00FD |=> accessError)
    else $error("alarm word write taken");
  a_ctrl_bits: assert property (wrStrobe && addr == 16'h00FC
    |=> outputsOff == $past(wrData[15]) && ioHold == $past(wrData[12]))
    else $error("hold or off bit not stored");
  a_restart_clear: assert property (restartDone[0] && !wrStrobe |=> !restartReq[0])
    else $error("restart bit not cleared");
  a_io_range: assert property (unitRdIdx > 8'hEB |=> unitRdData == 16'h0000)
    else $error("unit read past io area");
  a_out_off: assert property (outputsOff |=> unitRdData == 16'h0000)
    else $error("outputs shown while off");
  cover property (wrStrobe && addr == 16'h00FC);
  cover property (rdStrobe ##1 rdData != 16'h0000);
  cover property (accessError);
endmodule
bind plcdm_data_area_map plcdm_map_assertions chk_u (.clock, .arst_n, .addr, .wrData,
  .wrStrobe, .rdStrobe, .rdData, .accessError, .unitRdIdx, .unitRdData, .restartDone,
  .restartReq, .outputsOff, .ioHold);

/* File: plcdm_net_status.sv */
// network completion codes and link control/status word
`timescale 1ns/1ps
module plcdm_net_status (
  input wire logic clock,
  input wire logic rstSync_n,
  input wire logic [1:0] netDone,
  input wire logic [7:0] netCode0,
  input wire logic [7:0] netCode1,
  input wire logic progWr,
  input wire logic [15:0] progData,
  input wire logic [15:0] hwBits,
  input wire logic [2:0] restartDone,
  output logic [15:0] codeWord,
  output logic [15:0] ctrlWord
);
  logic [15:0] codeReg;
  logic [15:0] codeNext;
  logic [15:0] progReg;
  logic [15:0] progNext;
  logic [15:0] rstBits;

  assign rstBits = (16'h0001 << plcdm_pkg::LC_HOST1_RST)
    | (16'h0001 << plcdm_pkg::LC_CPUHL_RST) | (16'h0001 << plcdm_pkg::LC_HOST0_RST);

  always_comb begin
    codeNext = codeReg;
    if (netDone[0]) begin
      codeNext[7:0] = netCode0;
    end
    if (netDone[1]) begin
      codeNext[15:8] = netCode1;
    end
    progNext = progReg;
    // units clear their restart bit when done; a program write in that cycle wins
    if (restartDone[0]) begin
      progNext[plcdm_pkg::LC_HOST1_RST] = 1'b0;
    end
    if (restartDone[1]) begin
      progNext[plcdm_pkg::LC_CPUHL_RST] = 1'b0;
    end
    if (restartDone[2]) begin
      progNext[plcdm_pkg::LC_HOST0_RST] = 1'b0;
    end
    if (progWr) begin
      progNext = (progData & plcdm_pkg::LC_PROG_MASK) | (progNext & rstBits & progData);
      progNext = progNext | (progData & plcdm_pkg::LC_PROG_MASK);
    end
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      codeReg <= 16'h0000;
      progReg <= plcdm_pkg::LC_RESET;
    end else begin
      codeReg <= codeNext;
      progReg <= progNext;
    end
  end

  assign codeWord = codeReg;
  assign ctrlWord = (progReg & plcdm_pkg::LC_PROG_MASK) | (hwBits & ~plcdm_pkg::LC_PROG_MASK);
endmodule

/* File: plcdm_pkg.sv */
// constants, area codes and field layout of the controller data-area map
package plcdm_pkg;
  localparam int WORD_W = 16;

  typedef enum logic [2:0] {
    AREA_PLAIN = 3'h0,
    AREA_HOLD = 3'h1,
    AREA_AUX = 3'h2,
    AREA_LINK = 3'h3,
    AREA_DM = 3'h4,
    AREA_TC = 3'h5,
    AREA_TEMP = 3'h6,
    AREA_CFG = 3'h7
  } plcdm_area_e;

  // operand address layout
  localparam int ADDR_BITMODE = 15;
  localparam int ADDR_AREA_LSB = 12;

  // io, special, holding, aux, link, data memory, timer and config word ranges
  localparam logic [11:0] IO_LAST = 12'h0EB;
  localparam logic [11:0] IO_LOCAL_LAST = 12'h01D;
  localparam logic [11:0] IO_REMOTE_FIRST = 12'h032;
  localparam logic [11:0] IO_REMOTE_LAST = 12'h0E7;
  localparam logic [11:0] SP_FIRST = 12'h0EC;
  localparam logic [11:0] SP_WORK_LAST = 12'h0FB;
  localparam logic [11:0] SP_LAST = 12'h0FF;
  localparam logic [11:0] HOLD_LAST = 12'h063;
  localparam logic [11:0] AUX_LAST = 12'h01B;
  localparam logic [11:0] AUX_FREE_FIRST = 12'h007;
  localparam logic [11:0] AUX_FREE_LAST = 12'h016;
  localparam logic [11:0] LINK_LAST = 12'h03F;
  localparam logic [11:0] DM_RO_FIRST = 12'h3E8;
  localparam logic [11:0] DM_LAST = 12'h7CF;
  localparam logic [11:0] DM_LOG_FIRST = 12'h3C9;
  localparam logic [11:0] DM_LOG_LAST = 12'h3E7;
  localparam logic [11:0] TC_LAST = 12'h1FF;
  localparam logic [11:0] TEMP_LAST = 12'h007;
  localparam logic [11:0] CFG_LAST = 12'h001;

  // special-area dedicated words
  localparam logic [11:0] REG_NODE_LOOP = 12'h0EC;
  localparam logic [11:0] REG_NET_CODE = 12'h0ED;
  localparam logic [11:0] REG_L0_LINK = 12'h0EE;
  localparam logic [11:0] REG_L1_LINK = 12'h0F2;
  localparam logic [11:0] REG_UNUSED = 12'h0F6;
  localparam logic [11:0] REG_PEER = 12'h0F7;
  localparam logic [11:0] REG_REMOTE_ERR = 12'h0FB;
  localparam logic [11:0] REG_LINK_CTRL = 12'h0FC;
  localparam logic [11:0] REG_ALARM = 12'h0FD;

  // link_control_status fields
  localparam int LC_ERR0 = 0;
  localparam int LC_EN0 = 1;
  localparam int LC_RUN0 = 2;
  localparam int LC_HOST1_ERR = 6;
  localparam int LC_HOST1_RST = 7;
  localparam int LC_CPUHL_ERR = 8;
  localparam int LC_CPUHL_RST = 9;
  localparam int LC_FORCE_HOLD = 11;
  localparam int LC_IO_HOLD = 12;
  localparam int LC_HOST0_RST = 13;
  localparam int LC_OUT_OFF = 15;
  localparam logic [15:0] LC_PROG_MASK = 16'hBA80;
  localparam logic [15:0] LC_RESET = 16'h0000;

  // alarm_fault_status fields
  localparam int AL_BATT = 8;
  localparam int AL_CYCLE = 9;
  localparam int AL_IOVER = 10;
  localparam int AL_HOST0_ERR = 11;

  // own configuration words
  localparam logic [11:0] CFG_USE_MASK = 12'h000;
  localparam logic [11:0] CFG_CTRL = 12'h001;
  localparam logic [15:0] CFG_USE_MASK_RESET = 16'hFFFF;
  localparam logic [15:0] CFG_CTRL_RESET = 16'h0000;
  localparam int CTRL_LINK_USE = 0;

  localparam logic HAS_ERR_LOG = 1'b1;
endpackage

/* File: tb_top.sv */
// self-checking bench for the data-area map
`timescale 1ns/1ps
module tb_top;
  logic clock = 0, arst_n = 0, wrStrobe = 0, rdStrobe = 0, unitWr = 0, tcWr = 0, tcDone = 0;
  logic runStart = 0, accessError, outputsOff, forcedHold, ioHold;
  logic lowBattery, cycleTimeError, ioVerifyError;
  logic [15:0] addr = '0, wrData = '0, unitData = '0, tcPv = '0, rdData, unitRdData;
  logic [15:0] nodeLoopStatus, remoteIoErrors;
  logic [3:0][15:0] linkStatus0, linkStatus1, peerStatus;
  logic [11:0] unitIdx = '0;
  logic [8:0] tcIdx = '0;
  logic [7:0] unitRdIdx = '0, netCode0 = '0, netCode1 = '0, alarmNumber;
  logic [5:0] linkFlags;
  logic [2:0] unitArea = '0, restartDone = '0, restartReq, hostErrors;
  logic [1:0] netDone = '0;
  int failCount = 0, checkCount = 0;
  plcdm_far_model far_u (.nodeLoopStatus, .linkStatus0, .linkStatus1, .peerStatus,
    .remoteIoErrors, .linkFlags, .hostErrors, .alarmNumber, .lowBattery, .cycleTimeError,
    .ioVerifyError);
  plcdm_data_area_map dut_u (.clock, .arst_n, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
    .accessError, .unitWr, .unitArea, .unitIdx, .unitData, .unitRdIdx, .unitRdData, .tcWr,
    .tcIdx, .tcPv, .tcDone, .runStart, .nodeLoopStatus, .netDone, .netCode0, .netCode1,
    .linkStatus0, .linkStatus1, .peerStatus, .remoteIoErrors, .linkFlags, .hostErrors,
    .restartDone, .alarmNumber, .lowBattery, .cycleTimeError, .ioVerifyError, .restartReq,
    .outputsOff, .forcedHold, .ioHold);
  always #20 clock = ~clock;
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
    output logic [15:0] q, output logic e);
    @(posedge clock);
    wrStrobe <= w;
    rdStrobe <= !w;
    addr <= a;
    wrData <= d;
    @(posedge clock);
    wrStrobe <= 0;
    rdStrobe <= 0;
    @(negedge clock);
    q = rdData;
    e = accessError;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic err);
    logic [15:0] q;
    logic e;
    acc(0, a, '0, q, e);
    chk("rdData", q, exp);
    chk("accessError", e, err);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic err);
    logic [15:0] q;
    logic e;
    acc(1, a, d, q, e);
    chk("accessError", e, err);
  endtask
  task automatic uw(input logic [2:0] ar, input logic [11:0] i, input logic [15:0] d);
    @(posedge clock);
    unitWr <= 1;
    unitArea <= ar;
    unitIdx <= i;
    unitData <= d;
    @(posedge clock);
    unitWr <= 0;
  endtask
  task automatic ur(input logic [7:0] i, input logic [15:0] exp);
    @(posedge clock);
    unitRdIdx <= i;
    @(posedge clock);
    @(negedge clock);
    chk("unitRdData", unitRdData, exp);
  endtask
  task automatic pulseRun;
    @(posedge clock);
    runStart <= 1;
    @(posedge clock);
    runStart <= 0;
  endtask
  task automatic t_areas;
    logic [15:0] a[6] = '{16'h2007, 16'h2003, 16'h303F, 16'h43E7, 16'h43E8, 16'h00EB};
    logic e[6] = '{0, 1, 0, 0, 1, 0};
    for (int k = 0; k < 6; k++) begin
      wr(a[k], a[k] ^ 16'h5A5A, e[k]);
      if (!e[k]) rd(a[k], a[k] ^ 16'h5A5A, 0);
    end
    wr(16'h1005, 16'h1234, 0);
    wr(16'h9052, '0, 0);
    rd(16'h1005, 16'h1230, 0);
    rd(16'h9054, 16'h0001, 0);
    rd(16'hC005, '0, 1);
    rd(16'h6003, '0, 1);
    wr(16'h5005, 16'h0001, 1);
    rd(16'h0100, '0, 1);
    wr(16'h00FD, 16'h0001, 1);
    wr(16'h00EC, 16'h0001, 1);
    $display("areas test done");
  endtask
  task automatic t_unit;
    uw(3'h0, 12'h00A, 16'hBEEF);
    rd(16'h000A, 16'hBEEF, 0);
    ur(8'h0A, 16'hBEEF);
    ur(8'hEC, '0);
    uw(3'h4, 12'h3C9, 16'h0969);
    rd(16'h43C9, 16'h0969, 0);
    uw(3'h4, 12'h7CF, 16'h1999);
    rd(16'h47CF, 16'h1999, 0);
    wr(16'h3005, 16'h2222, 0);
    uw(3'h3, 12'h005, 16'h1111);
    rd(16'h3005, 16'h2222, 0);
    wr(16'h7001, 16'h0001, 0);
    uw(3'h3, 12'h005, 16'h1111);
    rd(16'h3005, 16'h1111, 0);
    $display("unit test done");
  endtask
  task automatic t_tc;
    @(posedge clock);
    tcWr <= 1;
    tcIdx <= 9'h1FF;
    tcPv <= 16'h0789;
    tcDone <= 1;
    @(posedge clock);
    tcWr <= 0;
    rd(16'h51FF, 16'h0789, 0);
    rd(16'hD1FF, 16'h0001, 0);
    wr(16'hE007, 16'h0001, 0);
    rd(16'hE007, 16'h0001, 0);
    $display("timer test done");
  endtask
  task automatic t_special;
    rd(16'h00EC, 16'hA55A, 0);
    for (int i = 0; i < 4; i++) begin
      rd(16'(16'h00EE + i), 16'(16'h4400 + i), 0);
      rd(16'(16'h00F2 + i), 16'(16'h8800 + i), 0);
      rd(16'(16'h00F7 + i), 16'(16'hC300 + i), 0);
    end
    rd(16'h00F6, '0, 0);
    rd(16'h00FB, 16'hF00F, 0);
    rd(16'h00FD, 16'h0DC3, 0);
    @(posedge clock);
    netCode0 <= 8'h12;
    netCode1 <= 8'h34;
    netDone <= 2'h3;
    @(posedge clock);
    netDone <= 2'h0;
    rd(16'h00ED, 16'h3412, 0);
    wr(16'h7000, 16'hFFFE, 0);
    wr(16'h00EC, 16'h1234, 0);
    rd(16'h00EC, 16'h1234, 0);
    wr(16'h7000, 16'hFFFF, 0);
    rd(16'h00EC, 16'hA55A, 0);
    $display("special test done");
  endtask
  task automatic t_ctrl;
    wr(16'h00FC, 16'hFFFF, 0);
    rd(16'h00FC, 16'hBAED, 0);
    chk("holds", {outputsOff, ioHold, forcedHold, restartReq}, 16'h003F);
    ur(8'h0A, '0);
    pulseRun;
    rd(16'h000A, 16'hBEEF, 0);
    @(posedge clock);
    restartDone <= 3'h3;
    @(posedge clock);
    restartDone <= 3'h0;
    @(negedge clock);
    chk("restartReq", restartReq, 16'h0004);
    wr(16'h00FC, '0, 0);
    chk("outputsOff", outputsOff, '0);
    pulseRun;
    rd(16'h000A, '0, 0);
    $display("control test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1;
    repeat (3) @(posedge clock);
    t_areas;
    t_unit;
    t_tc;
    t_special;
    t_ctrl;
    conclude;
  end
  // tests take under two hundred cycles; ten thousand is ample
  initial begin
    #400000;
    failCount++;
    conclude;
  end
endmodule
